// >>> hw/adcss_regs.svh
// register offsets, field positions and sizes of the scan sequencer
// assumes byte addresses of 16-bit registers on the plain register port
`ifndef ADCSS_REGS_SVH
`define ADCSS_REGS_SVH

`define ADCSS_AW 8
`define ADCSS_DW 16
`define ADCSS_CHW 4
`define ADCSS_RESW 10
`define ADCSS_NCH_DEF 10
`define ADCSS_NCH_MAX 16

`define ADCSS_OFS_CTRL 8'h20
`define ADCSS_OFS_SEL 8'h22
`define ADCSS_OFS_RES0 8'h24
`define ADCSS_RES_SHIFT 1

`define ADCSS_CTL_XTRIG 9
`define ADCSS_CTL_KICK 8
`define ADCSS_CTL_CH_HI 7
`define ADCSS_CTL_CH_LO 4
`define ADCSS_CTL_BUSY 3
`define ADCSS_CTL_DONE 1
`define ADCSS_CTL_IE 0

`define ADCSS_RST_CTRL 1'b0
`define ADCSS_RST_DATA 16'h0000

`endif

// >>> hw/adcss_pkg.sv
// types shared by the scan sequencer files
// assumes nothing of its surroundings
`default_nettype none
package adcss_pkg;
   typedef enum logic {ADCSS_IDLE, ADCSS_CONV} adcss_state_t;
endpackage
`default_nettype wire

// >>> hw/adcss_edge.sv
// two-flop synchroniser with rising edge detector for the trigger pin
// assumes pin_i is asynchronous to clock_i
`default_nettype none
module adcss_edge (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic pin_i,
   output logic rise_o
);
   logic meta_r;
   logic sync_r;
   logic last_r;
   logic rise_r;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rise_r <= 1'b0;
      end else begin
         rise_r <= sync_r & ~last_r;
      end
   end

   assign rise_o = rise_r;
endmodule // adcss_edge
`default_nettype wire

// >>> hw/adcss_seq.sv
// scan sequencer for a 10-channel successive approximation converter
// assumes a conversion core on clock_i that answers each start pulse
// with one core_done_i pulse and the value on core_data_i
//
// Contract
// - results ten bits, upper six zero, read-only
// - kick with one channel starts, sets busy
// - kick while running restarts from lowest channel
// - single finish clears busy, sets done
// - scan ascending, each result own register
// - unselected channels skipped during scan
// - busy clears, done sets after last
// - enabled trigger rising edge starts conversion
// - kick still starts with trigger enabled
// - trigger edge during conversion restarts sequence
// - interrupt while done and enable set
// - kick bit reads zero, zero ignored
`include "adcss_regs.svh"
`default_nettype none
module adcss_seq
   import adcss_pkg::*;
#(
   parameter int NCH = `ADCSS_NCH_DEF
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [`ADCSS_AW-1:0] addr_i,
   input wire logic [`ADCSS_DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`ADCSS_DW-1:0] rdata_o,
   input wire logic trig_pin_i,
   output logic conv_start_o,
   output logic conv_abort_o,
   output logic [`ADCSS_CHW-1:0] conv_chan_o,
   input wire logic core_done_i,
   input wire logic [`ADCSS_RESW-1:0] core_data_i,
   output logic busy_o,
   output logic irq_o
);
   localparam int CHW = `ADCSS_CHW;
   localparam int RW = `ADCSS_RESW;
   localparam int DW = `ADCSS_DW;

   if (NCH < 1 || NCH > `ADCSS_NCH_MAX) begin : g_bad_nch
      $error("adcss_seq: NCH must lie in 1..16");
   end

   adcss_state_t state_r;
   logic [NCH-1:0] sel_r;
   logic [NCH-1:0] mask_r;
   logic [CHW-1:0] chan_r;
   logic xtrig_en_r;
   logic ie_r;
   logic done_r;
   logic busy_r;
   logic start_r;
   logic abort_r;
   logic irq_r;
   logic [DW-1:0] rdata_r;
   logic [RW-1:0] result_r [NCH];
   logic trig_rise;

   // lowest set bit of mask at or above from; msb is the found flag
   function automatic logic [CHW:0] next_chan(
      input logic [NCH-1:0] mask,
      input int from
   );
      logic [CHW:0] res;
      res = '0;
      for (int i = 0; i < NCH; i++) begin
         if (!res[CHW] && mask[i] && i >= from) begin
            res = {1'b1, CHW'(i)};
         end
      end
      return res;
   endfunction

   // result register hit and index; msb is the hit flag
   function automatic logic [CHW:0] res_index(
      input logic [`ADCSS_AW-1:0] addr
   );
      logic [`ADCSS_AW-1:0] ofs;
      logic [CHW:0] res;
      res = '0;
      ofs = addr - `ADCSS_OFS_RES0;
      if (addr >= `ADCSS_OFS_RES0 && !ofs[0] &&
          int'(ofs >> `ADCSS_RES_SHIFT) < NCH) begin
         res = {1'b1, CHW'(ofs >> `ADCSS_RES_SHIFT)};
      end
      return res;
   endfunction

   adcss_edge u_trig (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .pin_i(trig_pin_i),
      .rise_o(trig_rise)
   );

   logic ctrl_wr;
   logic sel_wr;
   logic kick;
   logic trig_go;
   logic [CHW:0] first;
   logic go;
   logic core_take;
   logic [CHW:0] nxt;
   logic finish;
   logic [CHW:0] rd_res;

   assign ctrl_wr = wr_i && addr_i == `ADCSS_OFS_CTRL;
   assign sel_wr = wr_i && addr_i == `ADCSS_OFS_SEL;
   assign kick = ctrl_wr && wdata_i[`ADCSS_CTL_KICK];
   assign trig_go = trig_rise && xtrig_en_r;
   assign first = next_chan(sel_r, 0);
   // a kick or a trigger edge both start; either restarts a running scan
   assign go = (kick || trig_go) && first[CHW];
   assign core_take = state_r == ADCSS_CONV && core_done_i && !go;
   assign nxt = next_chan(mask_r, int'(chan_r) + 1);
   assign finish = core_take && !nxt[CHW];
   assign rd_res = res_index(addr_i);

   // control bits written by software
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         xtrig_en_r <= `ADCSS_RST_CTRL;
         ie_r <= `ADCSS_RST_CTRL;
      end else if (ctrl_wr) begin
         xtrig_en_r <= wdata_i[`ADCSS_CTL_XTRIG];
         ie_r <= wdata_i[`ADCSS_CTL_IE];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_r <= '0;
      end else if (sel_wr) begin
         sel_r <= wdata_i[NCH-1:0];
      end
   end

   // sequencer: snapshot the selection, walk it upward
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= ADCSS_IDLE;
         mask_r <= '0;
         chan_r <= '0;
         busy_r <= 1'b0;
      end else if (go) begin
         state_r <= ADCSS_CONV;
         mask_r <= sel_r;
         chan_r <= first[CHW-1:0];
         busy_r <= 1'b1;
      end else begin
         case (state_r)
            ADCSS_CONV: begin
               if (core_take && nxt[CHW]) begin
                  chan_r <= nxt[CHW-1:0];
               end else if (finish) begin
                  state_r <= ADCSS_IDLE;
                  busy_r <= 1'b0;
               end
            end
            default: begin
               state_r <= ADCSS_IDLE;
            end
         endcase
      end
   end

   // start pulse per channel; abort pulse in the same cycle on restart
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         start_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         start_r <= go || (core_take && nxt[CHW]);
         abort_r <= go && busy_r;
      end
   end

   // done flag: completion wins over a clearing write in the same cycle
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_r <= 1'b0;
      end else if (finish) begin
         done_r <= 1'b1;
      end else if (ctrl_wr && !wdata_i[`ADCSS_CTL_DONE]) begin
         done_r <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= done_r && ie_r;
      end
   end

   // per-channel results, written only by the core
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < NCH; i++) begin
            result_r[i] <= '0;
         end
      end else if (core_take) begin
         result_r[chan_r] <= core_data_i;
      end
   end

   // read port: data stand in the cycle after the strobe only
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_r <= `ADCSS_RST_DATA;
      end else if (!rd_i) begin
         rdata_r <= `ADCSS_RST_DATA;
      end else if (addr_i == `ADCSS_OFS_CTRL) begin
         rdata_r <= `ADCSS_RST_DATA;
         rdata_r[`ADCSS_CTL_XTRIG] <= xtrig_en_r;
         rdata_r[`ADCSS_CTL_CH_HI:`ADCSS_CTL_CH_LO] <= chan_r;
         rdata_r[`ADCSS_CTL_BUSY] <= busy_r;
         rdata_r[`ADCSS_CTL_DONE] <= done_r;
         rdata_r[`ADCSS_CTL_IE] <= ie_r;
      end else if (addr_i == `ADCSS_OFS_SEL) begin
         rdata_r <= DW'(sel_r);
      end else if (rd_res[CHW]) begin
         rdata_r <= DW'(result_r[rd_res[CHW-1:0]]);
      end else begin
         rdata_r <= `ADCSS_RST_DATA;
      end
   end

   assign rdata_o = rdata_r;
   assign conv_start_o = start_r;
   assign conv_abort_o = abort_r;
   assign conv_chan_o = chan_r;
   assign busy_o = busy_r;
   assign irq_o = irq_r;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   a_kick_sets_busy: assert property (
      kick && first[CHW] |=> busy_o && conv_start_o
         && conv_chan_o == $past(first[CHW-1:0]))
      else $error("kick did not start conversion");

   a_kick_xtrig_on: assert property (
      kick && xtrig_en_r && first[CHW] |=> conv_start_o)
      else $error("kick ignored with trigger enabled");

   a_restart_abort: assert property (
      kick && busy_r && first[CHW] |=> conv_abort_o && conv_start_o
         && conv_chan_o == $past(first[CHW-1:0]))
      else $error("restart did not reinitialise");

   a_trig_start: assert property (
      trig_rise && xtrig_en_r && first[CHW] |=> busy_o && conv_start_o)
      else $error("trigger edge did not start");

   a_trig_restart: assert property (
      trig_rise && xtrig_en_r && busy_r && first[CHW] |=> conv_abort_o)
      else $error("trigger edge did not restart");

   a_trig_off: assert property (
      !busy_r && trig_rise && !xtrig_en_r && !kick |=> !busy_o)
      else $error("disabled trigger started conversion");

   a_skip_unsel: assert property (
      conv_start_o |-> mask_r[conv_chan_o])
      else $error("unselected channel converted");

   a_scan_ascend: assert property (
      core_take && nxt[CHW] |=> conv_start_o && busy_o
         && conv_chan_o > $past(conv_chan_o))
      else $error("scan not ascending or ended early");

   a_result_store: assert property (
      core_take |=> result_r[$past(chan_r)] == $past(core_data_i))
      else $error("result not stored in own register");

   a_end_flags: assert property (
      finish |=> !busy_o ##0 done_r ##1 irq_o == $past(ie_r))
      else $error("end of scan flags wrong");

   a_busy_fall: assert property (
      $fell(busy_r) |-> done_r && $past(finish))
      else $error("busy dropped without completion");

   a_irq_follow: assert property (
      done_r && ie_r |=> irq_o)
      else $error("interrupt missing");

   a_done_clear: assert property (
      ctrl_wr && !wdata_i[`ADCSS_CTL_DONE] && !finish
         |=> !done_r ##1 !irq_o)
      else $error("done flag not cleared");

   a_kick_zero: assert property (
      rd_i && addr_i == `ADCSS_OFS_CTRL |=> !rdata_o[`ADCSS_CTL_KICK])
      else $error("kick bit read as one");

   a_result_upper: assert property (
      rd_i && rd_res[CHW] |=> rdata_o[DW-1:RW] == '0)
      else $error("result upper bits not zero");

   a_abort_pair: assert property (
      conv_abort_o |-> conv_start_o && busy_o)
      else $error("abort without a new start");

   // a start with nothing selected must leave the sequencer idle
   a_empty_ignore: assert property (
      (kick || trig_go) && !first[CHW] && !busy_r
         |=> !busy_o && !conv_start_o)
      else $error("start with empty selection accepted");

   a_single_end: assert property (
      finish && $onehot(mask_r)
         |=> !busy_o && done_r && !conv_start_o)
      else $error("single conversion end flags wrong");

   a_mask_hold: assert property (
      busy_r && !go |=> mask_r == $past(mask_r))
      else $error("selection snapshot changed during scan");

   a_rd_result: assert property (
      rd_i && rd_res[CHW]
         |=> rdata_o[RW-1:0] == $past(result_r[rd_res[CHW-1:0]]))
      else $error("result read back wrong");

   a_rdata_idle: assert property (
      !rd_i |=> rdata_o == '0)
      else $error("read data stands without a read");

   c_single: cover property (
      go && $onehot(sel_r) ##[1:300] finish);
   c_scan: cover property (
      go && !$onehot(sel_r) ##[1:600] finish);
   c_restart: cover property (conv_abort_o);
   c_trigger: cover property (trig_go && first[CHW]);
   c_trig_restart: cover property (trig_go && busy_r && first[CHW]);
endmodule // adcss_seq
`default_nettype wire

// >>> dv/adcss_core_model.sv
// behavioural conversion core: one done pulse per start not cut short by a new start, result per channel
// assumes start and channel come from the sequencer on the same clock
`default_nettype none
module adcss_core_model (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic [3:0] chan_i,
   input wire logic slow_i,
   output logic done_o,
   output logic [9:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r;
   logic [3:0] ch_r;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r <= 4'h0;
         ch_r <= 4'h0;
         done_o <= 1'b0;
         data_o <= 10'h000;
      end else begin
         // a new start drops the conversion in flight
         done_o <= (cnt_r == 4'h1) && !start_i;
         // result whenever cnt_r is 1, even when a new start drops done, inverted on every cycle in which cnt_r is not 1
         data_o <= (cnt_r == 4'h1) ? {ch_r, 6'h15} ^ 10'h0a5 : ~data_o;
         if (start_i) begin
            cnt_r <= slow_i ? 4'hf : 4'h2;
            ch_r <= chan_i;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule // adcss_core_model
`default_nettype wire

// >>> dv/test_adc_scan_sequencer.sv
// self-checking bench of the scan sequencer with a behavioural core
// assumes the sequencer register map and a 250 MHz clock
`include "adcss_regs.svh"
`default_nettype none
module test_adc_scan_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, wr, rd, trig, start, abort, cdone, busy, irq, slow;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [3:0] chan;
   logic [9:0] cdata;
   logic [3:0] seen[$];
   int n_abort, mismatches, n_compared, cycles;

   adcss_seq adcss_seq_inst (.clock_i(clk), .rstn_i(rstn), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .trig_pin_i(trig), .conv_start_o(start), .conv_abort_o(abort),
      .conv_chan_o(chan), .core_done_i(cdone), .core_data_i(cdata),
      .busy_o(busy), .irq_o(irq));
   adcss_core_model adcss_core_model_inst (.clock_i(clk), .rstn_i(rstn),
      .start_i(start), .chan_i(chan), .slow_i(slow), .done_o(cdone),
      .data_o(cdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (start === 1'b1) seen.push_back(chan);
      if (abort === 1'b1) n_abort++;
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (mismatches == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] m,
                         input logic [15:0] e);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e);
      @(posedge clk);
   endtask
   function automatic logic [15:0] res(input logic [3:0] c);
      return {6'h00, {c, 6'h15} ^ 10'h0a5};
   endfunction
   task automatic wait_idle();
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
      chk({15'h0, busy}, 16'h0000);
   endtask

   task automatic t_reset();
      rd_chk(`ADCSS_OFS_CTRL, 16'hffff, 16'h0000);
      rd_chk(`ADCSS_OFS_SEL, 16'hffff, 16'h0000);
      rd_chk(`ADCSS_OFS_RES0, 16'hffff, 16'h0000);
      rd_chk(8'h40, 16'hffff, 16'h0000);
      wr_reg(`ADCSS_OFS_CTRL, 16'h0100);
      rd_chk(`ADCSS_OFS_CTRL, 16'hffff, 16'h0000);
   endtask
   task automatic t_single();
      wr_reg(`ADCSS_OFS_SEL, 16'h0020);
      wr_reg(`ADCSS_OFS_CTRL, 16'h0101);
      rd_chk(`ADCSS_OFS_CTRL, 16'hffff, 16'h0059);
      wait_idle();
      rd_chk(`ADCSS_OFS_CTRL, 16'hff0f, 16'h0003);
      chk({15'h0, irq}, 16'h0001);
      rd_chk(8'h2e, 16'hffff, res(4'h5));
      wr_reg(8'h2e, 16'hffff);
      rd_chk(8'h2e, 16'hffff, res(4'h5));
      wr_reg(`ADCSS_OFS_CTRL, 16'h0001);
      rd_chk(`ADCSS_OFS_CTRL, 16'hff0f, 16'h0001);
      chk({15'h0, irq}, 16'h0000);
   endtask
   task automatic t_scan();
      logic [3:0] ex[4] = '{4'h0, 4'h2, 4'h5, 4'h9};
      slow <= 1'b0;
      seen.delete();
      wr_reg(`ADCSS_OFS_SEL, 16'h0225);
      wr_reg(`ADCSS_OFS_CTRL, 16'h0100);
      rd_chk(`ADCSS_OFS_CTRL, 16'h000a, 16'h0008);
      wait_idle();
      rd_chk(`ADCSS_OFS_CTRL, 16'h000b, 16'h0002);
      chk({15'h0, irq}, 16'h0000);
      wr_reg(`ADCSS_OFS_CTRL, 16'h0002);
      rd_chk(`ADCSS_OFS_CTRL, 16'h000b, 16'h0002);
      chk(16'(seen.size()), 16'h0004);
      for (int i = 0; i < 4; i++) begin
         chk({12'h0, seen[i]}, {12'h0, ex[i]});
         rd_chk(8'h24 + 8'(2 * ex[i]), 16'hffff, res(ex[i]));
      end
      rd_chk(8'h26, 16'hffff, 16'h0000);
   endtask
   task automatic t_restart();
      slow <= 1'b1;
      wr_reg(`ADCSS_OFS_SEL, 16'h0006);
      seen.delete();
      n_abort = 0;
      wr_reg(`ADCSS_OFS_CTRL, 16'h0100);
      wr_reg(`ADCSS_OFS_CTRL, 16'h0100);
      wait_idle();
      chk(16'(seen.size()), 16'h0003);
      chk({12'h0, seen[1]}, 16'h0001);
      chk(16'(n_abort), 16'h0001);
   endtask
   task automatic t_trig();
      wr_reg(`ADCSS_OFS_SEL, 16'h0008);
      wr_reg(`ADCSS_OFS_CTRL, 16'h0200);
      seen.delete();
      n_abort = 0;
      trig <= 1'b1;
      repeat (8) @(posedge clk);
      chk({15'h0, busy}, 16'h0001);
      trig <= 1'b0;
      repeat (4) @(posedge clk);
      trig <= 1'b1;
      repeat (8) @(posedge clk);
      chk(16'(n_abort), 16'h0001);
      wait_idle();
      wr_reg(`ADCSS_OFS_CTRL, 16'h0300);
      rd_chk(`ADCSS_OFS_CTRL, 16'h0008, 16'h0008);
      wait_idle();
      chk(16'(seen.size()), 16'h0003);
      wr_reg(`ADCSS_OFS_CTRL, 16'h0000);
      trig <= 1'b0;
      repeat (4) @(posedge clk);
      trig <= 1'b1;
      repeat (8) @(posedge clk);
      chk({15'h0, busy}, 16'h0000);
   endtask

   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      trig = 1'b0;
      slow = 1'b1;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_single();
      t_scan();
      t_restart();
      t_trig();
      tally_and_finish();
   end
endmodule // test_adc_scan_sequencer
`default_nettype wire
